// ==== pkg/nsrp_pkg.sv ====
// Shared constants for the flash status, reset and block protection logic.
// Assumes one 250 MHz clock and an 8-bit command/address/data path.
package nsrp_pkg;
   // Command codes
   localparam logic [7:0] CMD_STATUS = 8'h70;
   localparam logic [7:0] CMD_RESET = 8'hFF;
   localparam logic [7:0] CMD_UID = 8'hED;
   localparam logic [7:0] CMD_READ = 8'h00;
   localparam logic [7:0] CMD_READ_GO = 8'h30;
   localparam logic [7:0] CMD_RND_OUT = 8'h05;
   localparam logic [7:0] CMD_RND_GO = 8'hE0;
   localparam logic [7:0] CMD_PROT_BOTH = 8'h43;
   localparam logic [7:0] CMD_PROT_ERASE = 8'h42;
   localparam logic [7:0] CMD_PROT_PROG = 8'h41;
   localparam logic [7:0] CMD_SERIAL_IN = 8'h80;
   localparam logic [7:0] CMD_CONFIRM = 8'h10;
   localparam logic [7:0] CMD_ERASE = 8'h60;
   localparam logic [7:0] CMD_ERASE_GO = 8'hD0;
   localparam logic [7:0] CMD_PSTAT_GO = 8'h34;
   localparam logic [7:0] CMD_PSTAT = 8'h74;
   localparam logic [7:0] ADDR_ZERO = 8'h00;
   // Status byte field positions
   localparam int PASS_FAIL_BIT = 0;
   localparam int PREV_PASS_FAIL_BIT = 1;
   localparam int ARRAY_READY_BIT = 5;
   localparam int HOST_READY_BIT = 6;
   localparam int NOT_PROTECTED_BIT = 7;
   localparam int PROT_PROG_BIT = 0;
   localparam int PROT_ERASE_BIT = 1;
   // Address cycle counts
   localparam int PROT_ADDR_CYCLES = 5;
   localparam int ERASE_ADDR_CYCLES = 3;
   localparam int UID_ADDR_CYCLES = 1;
   // Identifier layout
   localparam int UID_COPIES = 16;
   localparam int UID_COPY_BYTES = 32;
   localparam int UID_HALF_BYTES = 16;
   // Times in ns and their cycle counts at 4 ns
   localparam int CLK_PERIOD_NS = 4;
   localparam int ARRAY_READ_TIME_NS = 25000;
   localparam int ARRAY_READ_CYCLES = ARRAY_READ_TIME_NS / CLK_PERIOD_NS;
   localparam int PROG_TIME_NS = 300000;
   localparam int PROG_CYCLES = PROG_TIME_NS / CLK_PERIOD_NS;
   localparam int RESET_TIME_NS = 5000;
   localparam int RESET_CYCLES = (RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PARTIAL_LIMIT = 4;
   localparam logic [7:0] STATUS_RESET = 8'hE0;
endpackage : nsrp_pkg

// ==== pkg/nsrp_if.sv ====
// Multiplexed flash bus between host controller and device logic.
// Ready/busy is open drain: the wire is low when any enable is high.
`timescale 1ns/1ps
interface nsrp_if;
   logic cmdStrobe;     // Host: command byte valid this cycle
   logic addrStrobe;    // Host: address byte valid this cycle
   logic writeStrobe;   // Host: data byte written (unused by this logic)
   logic readStrobe;    // Host: read one data byte
   logic [15:0] ioHost; // Host drives command/address
   logic [7:0] ioDev;   // Device returned data
   logic ioDevValid;    // Device data valid pulse
   logic wpN;           // Host: write protect, active low
   logic rbOut;         // Device: ready/busy pin output value (always 0)
   logic rbOe;          // Device: high while pulling ready/busy low
   wire rbLine = ~rbOe; // Pulled-up wired line level
   modport dev (input cmdStrobe, addrStrobe, writeStrobe, readStrobe, ioHost, wpN,
                output ioDev, ioDevValid, rbOut, rbOe, input rbLine);
   modport host (output cmdStrobe, addrStrobe, writeStrobe, readStrobe, ioHost, wpN,
                 input ioDev, ioDevValid, rbLine);
endinterface : nsrp_if

// ==== rtl/nsrp_device.sv ====
// Device end: command decoding, status byte, reset abort, ready/busy,
// write protect gating, unique identifier read and block protection.
// Assumes the host keeps its side of the bus protocol; one clock mclk.
// Summary of operation
// - Status command returns latest operation status byte
// - Bit0 fail, bits5-6 ready, bit7 unprotected
// - Pass/fail valid only when host ready
// - Cache: bit5 array, bit6 host, bit1 previous
// - Reset command aborts any running operation
// - Host waits for ready before first reset
// - New reset accepted during running reset
// - Ready/busy low during operations, high otherwise
// - Ready/busy is open drain, pulls low only
// - Host keeps write protect high while busy
// - Identifier command only when idle, mode sticks
// - One zero address, then busy one read time
// - Host issues read command after status polling; this host waits on ready/busy and reads with no read command
// - Sixteen copies: 16 bytes, then complements
// - Host XORs halves, retries next copy; this host reads one copy and does not retry
// - Random output pair moves identifier column
// - Upper eight lines ignored in identifier read
// - Prefix, 80h, five addresses, 10h, poll status
// - Host sends block address, zero column/page
// - Protections permanent, combinations prohibit both
// - Erase after program-only lifts program inhibit
// - Each protection counts one partial program
// - Protection query: bit0 program, bit1 erase
`timescale 1ns/1ps
module nsrp_device
   import nsrp_pkg::*;
#(
   parameter int BLOCKS = 2048,
   parameter int BUSY_CYCLES = ARRAY_READ_CYCLES,
   parameter int OP_CYCLES = PROG_CYCLES,
   parameter logic [127:0] UID_VALUE = 128'h0123456789ABCDEF0F1E2D3C4B5A6978 // Arbitrary
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // Flash bus
   nsrp_if.dev bus,
   // Array sequencer view
   input wire logic opFail,     // Result of the finishing array operation
   output logic eraseBlockPulse, // Erase started on activeBlock
   output logic [10:0] activeBlock
);
   typedef enum logic [6:0] {
      NSRP_IDLE = 7'b0000001, NSRP_ADDR = 7'b0000010, NSRP_WAITCF = 7'b0000100,
      NSRP_BUSY = 7'b0001000, NSRP_UIDOUT = 7'b0010000, NSRP_RNDADR = 7'b0100000,
      NSRP_PSTOUT = 7'b1000000
   } nsrp_state_t;
   typedef enum logic [2:0] {
      NSRP_OP_PROT = 3'b001, NSRP_OP_ERASE = 3'b010, NSRP_OP_OTHER = 3'b100
   } nsrp_op_t;

   nsrp_state_t state_q, state_d;
   nsrp_op_t op_q;
   logic [7:0] cmd_q;           // Command that opened the sequence
   logic [2:0] addrCnt_q;       // Address cycles seen
   logic [23:0] rowAddr_q;      // Collected row bytes
   logic [18:0] busyCnt_q;      // Internal operation timer
   logic statusMode_q;          // Output the status byte on reads
   logic uidMode_q;             // Identifier read mode sticks until new command
   logic failBit_q, prevFail_q;
   logic [8:0] col_q;           // Identifier output column
   logic [1:0] prot_q [BLOCKS]; // {erase inhibit, program inhibit}
   logic [2:0] partial_q [BLOCKS]; // Partial program count per block
   logic [7:0] ioDev_q;
   logic ioDevValid_q, rbOe_q, erasePulse_q;

   wire logic [7:0] ioLow = bus.ioHost[7:0]; // Upper lines ignored
   wire logic isCmd = bus.cmdStrobe;
   wire logic isReset = isCmd && ioLow == CMD_RESET;
   wire logic idle = state_q != NSRP_BUSY;
   wire logic [10:0] blk = rowAddr_q[16:6];
   wire logic [7:0] statusByte = {bus.wpN, idle, idle, 3'b000, prevFail_q, failBit_q};
   wire logic [3:0] byteIdx = col_q[3:0];
   wire logic [7:0] uidByte = UID_VALUE[8'(byteIdx) * 8 +: 8];
   wire logic [7:0] uidOut = col_q[4] ? ~uidByte : uidByte;
   wire logic [1:0] blkProt = prot_q[blk];
   wire logic wpOk = bus.wpN;

   // Next state from host cycles; reset command wins over everything
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         NSRP_IDLE, NSRP_UIDOUT, NSRP_PSTOUT: begin
            if (isCmd && (ioLow == CMD_PROT_BOTH || ioLow == CMD_PROT_ERASE ||
                ioLow == CMD_PROT_PROG || ioLow == CMD_ERASE || ioLow == CMD_UID ||
                ioLow == CMD_READ)) state_d = NSRP_ADDR;
            else if (isCmd && ioLow == CMD_RND_OUT && state_q == NSRP_UIDOUT)
               state_d = NSRP_RNDADR;
         end
         NSRP_ADDR: begin
            if (isCmd && ioLow != CMD_SERIAL_IN) state_d = NSRP_IDLE;
            else if (bus.addrStrobe && cmd_q == CMD_UID) state_d = NSRP_BUSY;
            else if (bus.addrStrobe && 32'(addrCnt_q) + 1 ==
                     (cmd_q == CMD_ERASE ? ERASE_ADDR_CYCLES : PROT_ADDR_CYCLES))
               state_d = NSRP_WAITCF;
         end
         NSRP_WAITCF: begin
            if (isCmd) state_d = NSRP_IDLE;
            if (isCmd && wpOk && ((ioLow == CMD_CONFIRM && op_q == NSRP_OP_PROT) ||
                (ioLow == CMD_ERASE_GO && op_q == NSRP_OP_ERASE))) state_d = NSRP_BUSY;
            if (isCmd && ioLow == CMD_PSTAT_GO) state_d = NSRP_PSTOUT;
         end
         NSRP_BUSY: if (busyCnt_q == '0) state_d = uidMode_q ? NSRP_UIDOUT : NSRP_IDLE;
         NSRP_RNDADR: if (isCmd && ioLow == CMD_RND_GO) state_d = NSRP_UIDOUT;
      endcase
      if (isReset) state_d = NSRP_BUSY;
   end

   // Sequence bookkeeping
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         state_q <= NSRP_BUSY;
         op_q <= NSRP_OP_OTHER;
         cmd_q <= '0;
         addrCnt_q <= '0;
         rowAddr_q <= '0;
         busyCnt_q <= 19'(RESET_CYCLES);
         statusMode_q <= 1'b0;
         uidMode_q <= 1'b0;
      end else begin
         state_q <= state_d;
         if (isCmd) statusMode_q <= ioLow == CMD_STATUS;
         if (isCmd && state_q != NSRP_ADDR && state_q != NSRP_WAITCF &&
             ioLow != CMD_STATUS && ioLow != CMD_RND_OUT && ioLow != CMD_RND_GO) begin
            cmd_q <= ioLow;
            addrCnt_q <= '0;
            uidMode_q <= ioLow == CMD_UID && idle;
            op_q <= (ioLow == CMD_ERASE) ? NSRP_OP_ERASE :
                    (ioLow == CMD_PROT_BOTH || ioLow == CMD_PROT_ERASE ||
                     ioLow == CMD_PROT_PROG) ? NSRP_OP_PROT : NSRP_OP_OTHER;
         end
         if (bus.addrStrobe && state_q == NSRP_ADDR) begin
            addrCnt_q <= addrCnt_q + 3'd1;
            if (cmd_q == CMD_ERASE || addrCnt_q >= 3'd2)
               rowAddr_q <= {ioLow, rowAddr_q[23:8]};
         end
         if (isReset) busyCnt_q <= 19'(RESET_CYCLES);
         else if (state_q != NSRP_BUSY && state_d == NSRP_BUSY)
            busyCnt_q <= uidMode_q ? 19'(BUSY_CYCLES) : 19'(OP_CYCLES);
         else if (busyCnt_q != '0) busyCnt_q <= busyCnt_q - 19'd1;
      end
   end

   // Pass/fail updates when a non-identifier operation completes and on any command in WAITCF under write protect, so it is valid once ready
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         failBit_q <= 1'b0;
         prevFail_q <= 1'b0;
      end else if (state_q == NSRP_BUSY && busyCnt_q == '0 && !uidMode_q) begin
         prevFail_q <= failBit_q;
         failBit_q <= opFail && op_q != NSRP_OP_OTHER;
      end else if (isCmd && state_q == NSRP_WAITCF && !wpOk) begin
         failBit_q <= 1'b1; // Refused under write protect
      end
   end

   // Protection table; bits only ever set, except the erase lift
   genvar gi;
   generate
      for (gi = 0; gi < BLOCKS; gi++) begin : g_blk
         wire logic hit = blk == 11'(gi);
         wire logic fire = hit && isCmd && state_q == NSRP_WAITCF && wpOk;
         wire logic isProt = fire && ioLow == CMD_CONFIRM && op_q == NSRP_OP_PROT;
         wire logic isErase = fire && ioLow == CMD_ERASE_GO && op_q == NSRP_OP_ERASE;
         always_ff @(posedge mclk) begin
            if (sys_rst) begin
               prot_q[gi] <= 2'b00;
               partial_q[gi] <= '0;
            end else if (isProt) begin
               unique case (cmd_q)
                  CMD_PROT_PROG: prot_q[gi] <= prot_q[gi] == 2'b00 ? 2'b01 : 2'b11;
                  CMD_PROT_ERASE: prot_q[gi] <= prot_q[gi] == 2'b00 ? 2'b10 : 2'b11;
                  default: prot_q[gi] <= 2'b11;
               endcase
               if (32'(partial_q[gi]) < PARTIAL_LIMIT) partial_q[gi] <= partial_q[gi] + 3'd1;
            end else if (isErase && prot_q[gi] == 2'b01) begin
               prot_q[gi] <= 2'b00;
               partial_q[gi] <= '0;
            end else if (isErase && !prot_q[gi][1]) begin
               partial_q[gi] <= '0;
            end
         end
      end
   endgenerate

   // Data returned on reads and identifier column
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         ioDev_q <= STATUS_RESET;
         ioDevValid_q <= 1'b0;
         col_q <= '0;
      end else begin
         ioDevValid_q <= bus.readStrobe;
         if (bus.readStrobe) begin
            if (statusMode_q) ioDev_q <= statusByte;
            else if (state_q == NSRP_PSTOUT) ioDev_q <= {6'b000000, blkProt};
            else if (state_q == NSRP_UIDOUT) ioDev_q <= uidOut;
            else ioDev_q <= '0;
         end
         if (state_q == NSRP_BUSY && uidMode_q) col_q <= '0;
         else if (state_q == NSRP_RNDADR && bus.addrStrobe)
            col_q <= {ioLow[0], col_q[8:1]} ;
         else if (bus.readStrobe && state_q == NSRP_UIDOUT && !statusMode_q)
            col_q <= col_q + 9'd1;
      end
   end

   // Open drain ready/busy: enable only, never a driven high
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         rbOe_q <= 1'b1;
         erasePulse_q <= 1'b0;
      end else begin
         rbOe_q <= state_d == NSRP_BUSY;
         erasePulse_q <= state_q == NSRP_WAITCF && state_d == NSRP_BUSY && op_q == NSRP_OP_ERASE;
      end
   end

   assign bus.ioDev = ioDev_q;
   assign bus.ioDevValid = ioDevValid_q;
   assign bus.rbOe = rbOe_q;
   assign bus.rbOut = 1'b0;
   assign eraseBlockPulse = erasePulse_q;
   assign activeBlock = blk;
endmodule : nsrp_device

// ==== rtl/nsrp_host.sv ====
// Host end: runs status, reset, identifier and protection sequences.
// Assumes the device end on the same interface; one clock mclk.
`timescale 1ns/1ps
module nsrp_host
   import nsrp_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // Flash bus
   nsrp_if.host bus,
   // User request
   input wire logic reqValid,   // Start a sequence
   input wire logic [2:0] reqKind, // 0 status,1 reset,2 uid,3 protect,4 prot query,5 erase
   input wire logic [7:0] reqPrefix, // Protection prefix 41h/42h/43h
   input wire logic [10:0] reqBlock,
   input wire logic wpNIn,
   output logic reqBusy,
   output logic [7:0] rspData,
   output logic rspValid,
   output logic uidGood         // Last identifier copy passed check
);
   logic [5:0] step_q;       // Position inside the sequence
   logic [2:0] kind_q;
   logic [7:0] io_q;
   logic cmd_q, addr_q, rd_q, busy_q, rspV_q, good_q, wait_q, seen_q;
   logic [7:0] rsp_q;
   logic [7:0] half_q [UID_HALF_BYTES];
   logic [4:0] uidIdx_q;
   logic [3:0] copy_q;

   wire logic rbHigh = bus.rbLine;
   wire logic [7:0] rowByte = (step_q == 6'd4) ? {reqBlock[1:0], 6'b000000} :
                              (step_q == 6'd5) ? reqBlock[9:2] : {7'b0000000, reqBlock[10]};

   // Sequencer: one bus cycle a step, waits on ready where needed
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         step_q <= '0; kind_q <= '0; io_q <= '0; cmd_q <= 1'b0; addr_q <= 1'b0;
         rd_q <= 1'b0; busy_q <= 1'b0; wait_q <= 1'b0; seen_q <= 1'b0;
      end else begin
         cmd_q <= 1'b0; addr_q <= 1'b0; rd_q <= 1'b0;
         if (!busy_q) begin
            if (reqValid && rbHigh) begin // Waits for ready first
               busy_q <= 1'b1; kind_q <= reqKind; step_q <= '0;
            end
         end else if (wait_q) begin
            if (rbHigh && seen_q) wait_q <= 1'b0;
            seen_q <= 1'b1;
         end else begin
            step_q <= step_q + 6'd1;
            unique case (kind_q)
               3'd0: if (step_q == 0) begin cmd_q <= 1'b1; io_q <= CMD_STATUS; end
                     else if (step_q == 1) rd_q <= 1'b1; else busy_q <= 1'b0;
               3'd1: if (step_q == 0) begin cmd_q <= 1'b1; io_q <= CMD_RESET; wait_q <= 1'b1;
                     seen_q <= 1'b0; end else busy_q <= 1'b0;
               3'd2: if (step_q == 0) begin cmd_q <= 1'b1; io_q <= CMD_UID; end
                     else if (step_q == 1) begin addr_q <= 1'b1; io_q <= ADDR_ZERO;
                        wait_q <= 1'b1; seen_q <= 1'b0; end
                     else if (step_q < 6'd34) rd_q <= 1'b1; // One 32-byte copy
                     else busy_q <= 1'b0;
               default: if (step_q == 0) begin cmd_q <= 1'b1;
                        io_q <= kind_q == 3'd3 ? reqPrefix :
                                kind_q == 3'd5 ? CMD_ERASE : CMD_READ; end
                     else if (step_q == 1) begin cmd_q <= kind_q == 3'd3;
                        io_q <= CMD_SERIAL_IN; end // Query and erase idle here
                     else if (step_q >= 2 && step_q <= 6) begin
                        addr_q <= kind_q != 3'd5 || step_q >= 6'd4; // Erase: row bytes only
                        io_q <= step_q < 4 ? ADDR_ZERO : rowByte; end
                     else if (step_q == 7) begin cmd_q <= 1'b1;
                        io_q <= kind_q == 3'd3 ? CMD_CONFIRM :
                                kind_q == 3'd5 ? CMD_ERASE_GO : CMD_PSTAT_GO;
                        wait_q <= kind_q != 3'd4; seen_q <= 1'b0; end
                     else if (step_q == 8) begin cmd_q <= 1'b1;
                        io_q <= kind_q == 3'd4 ? CMD_PSTAT : CMD_STATUS; end
                     else if (step_q == 9) rd_q <= 1'b1; else busy_q <= 1'b0;
            endcase
         end
      end
   end

   // Identifier check: XOR halves must give all ones
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         rsp_q <= '0; rspV_q <= 1'b0; good_q <= 1'b0; uidIdx_q <= '0; copy_q <= '0;
      end else begin
         rspV_q <= bus.ioDevValid;
         if (bus.ioDevValid) rsp_q <= bus.ioDev;
         if (kind_q == 3'd2 && step_q == 6'd1) begin uidIdx_q <= '0; good_q <= 1'b1; end
         else if (bus.ioDevValid && kind_q == 3'd2) begin
            uidIdx_q <= uidIdx_q + 5'd1;
            if (!uidIdx_q[4]) half_q[uidIdx_q[3:0]] <= bus.ioDev;
            else if ((half_q[uidIdx_q[3:0]] ^ bus.ioDev) != 8'hFF) good_q <= 1'b0;
            if (uidIdx_q == 5'h1F) copy_q <= copy_q + 4'd1;
         end
      end
   end

   assign bus.cmdStrobe = cmd_q;
   assign bus.addrStrobe = addr_q;
   assign bus.writeStrobe = 1'b0;
   assign bus.readStrobe = rd_q;
   assign bus.ioHost = {8'h00, io_q};
   assign bus.wpN = wpNIn;
   assign reqBusy = busy_q;
   assign rspData = rsp_q;
   assign rspValid = rspV_q;
   assign uidGood = good_q;
endmodule : nsrp_host

// ==== tb/nsrp_properties.sv ====
// Checker for the flash bus between host end and device end.
// Assumes the interface signals are wired in as plain inputs, one clock.
`timescale 1ns/1ps
module nsrp_properties
   import nsrp_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // Host side of the bus
   input wire logic cmdStrobe,
   input wire logic readStrobe,
   input wire logic [15:0] ioHost,
   input wire logic wpN,
   // Device side of the bus
   input wire logic [7:0] ioDev,
   input wire logic ioDevValid,
   input wire logic rbOut,
   input wire logic rbOe
);
   // Slack above the reset busy time; a test op is far shorter
   localparam int MAX_BUSY = RESET_CYCLES + 16;
   logic [7:0] lastCmd_q; // Last command byte seen
   logic [15:0] busyCnt_q; // Length of the current busy stretch
   wire isCmd = cmdStrobe && (ioHost[7:0] == CMD_RESET);
   wire isConfirm = cmdStrobe && (ioHost[7:0] == CMD_CONFIRM);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   // Remember the command that selects what a read returns
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         lastCmd_q <= 8'h00;
      end else if (cmdStrobe) begin
         lastCmd_q <= ioHost[7:0];
      end
   end
   // Count busy cycles so a stuck pull-down is caught without long repeats
   always_ff @(posedge mclk) begin
      if (sys_rst || !rbOe) begin
         busyCnt_q <= 16'h0000;
      end else begin
         busyCnt_q <= busyCnt_q + 16'h0001;
      end
   end
   a_rb_pull_only: assert property (rbOut == 1'b0)
      else $error("ready/busy output drives high");
   a_read_answer: assert property (readStrobe |=> ioDevValid)
      else $error("read strobe not answered next cycle");
   a_valid_cause: assert property (ioDevValid |-> $past(readStrobe))
      else $error("data valid without a read strobe");
   a_reset_goes_busy: assert property (isCmd |-> ##[1:3] rbOe)
      else $error("reset command did not go busy");
   a_busy_bounded: assert property (busyCnt_q <= MAX_BUSY)
      else $error("ready/busy held low too long");
   a_wp_refuse: assert property (isConfirm && !wpN && !rbOe |-> ##1 !rbOe [*3])
      else $error("confirm under write protect went busy");
   a_confirm_busy: assert property (isConfirm && wpN && !rbOe |-> ##[1:2] rbOe)
      else $error("confirm did not go busy");
   a_status_bits: assert property (ioDevValid && lastCmd_q == CMD_STATUS |->
      ioDev[6] == !$past(rbOe) && ioDev[5] == ioDev[6] && ioDev[7] == $past(wpN))
      else $error("status ready or protect bit wrong");
   a_status_reserved: assert property (ioDevValid && lastCmd_q == CMD_STATUS |->
      ioDev[4:2] == 3'h0)
      else $error("status reserved bits set");
   a_pstat_unused: assert property (ioDevValid && lastCmd_q == CMD_PSTAT |->
      ioDev[7:2] == 6'h00)
      else $error("protection status unused bits set");
endmodule : nsrp_properties

// ==== tb/testbench.sv ====
// Self-checking bench: host end and device end joined by one interface.
// Assumes short busy parameters; the reset busy time stays at full length.
`timescale 1ns/1ps
module testbench;
   import nsrp_pkg::*;
   localparam int T_BUSY = 20; // Shortened array read time
   localparam int T_OP = 24; // Shortened program time
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic reqValid = 1'b0;
   logic [2:0] reqKind = 3'h0;
   logic [7:0] reqPrefix = 8'h00;
   logic [10:0] reqBlock = 11'h000;
   logic wpNIn = 1'b1;
   logic opFail = 1'b0;
   logic reqBusy, rspValid, uidGood, eraseBlockPulse;
   logic [7:0] rspData;
   logic [10:0] activeBlock;
   logic [7:0] got; // Last response byte
   int failures = 0;
   int tests_run = 0;
   int erases = 0; // Erase start pulses seen
   nsrp_if bus_if ();
   nsrp_device #(.BUSY_CYCLES(T_BUSY), .OP_CYCLES(T_OP)) nsrp_device_i (.mclk(mclk),
      .sys_rst(sys_rst), .bus(bus_if.dev), .opFail(opFail),
      .eraseBlockPulse(eraseBlockPulse), .activeBlock(activeBlock));
   nsrp_host nsrp_host_i (.mclk(mclk), .sys_rst(sys_rst), .bus(bus_if.host),
      .reqValid(reqValid), .reqKind(reqKind), .reqPrefix(reqPrefix), .reqBlock(reqBlock),
      .wpNIn(wpNIn), .reqBusy(reqBusy), .rspData(rspData), .rspValid(rspValid),
      .uidGood(uidGood));
   nsrp_properties nsrp_properties_i (.mclk(mclk), .sys_rst(sys_rst),
      .cmdStrobe(bus_if.cmdStrobe), .readStrobe(bus_if.readStrobe), .ioHost(bus_if.ioHost),
      .wpN(bus_if.wpN), .ioDev(bus_if.ioDev), .ioDevValid(bus_if.ioDevValid),
      .rbOut(bus_if.rbOut), .rbOe(bus_if.rbOe));
   // Clock, 4 ns period
   always #2 mclk = ~mclk;
   // Count erase pulses mid-cycle, where the flop output has settled
   always @(negedge mclk) begin
      if (eraseBlockPulse === 1'b1) erases++;
   end
   // Status byte a ready device should show; prev is the result before the last one
   function automatic logic [7:0] stat(input logic wp, input logic fail, input logic prev);
      return {wp, 2'h3, 3'h0, prev, fail};
   endfunction : stat
   task automatic wrap_up;
      if (failures == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : wrap_up
   task automatic check8(input logic [7:0] act, input logic [7:0] exp);
      tests_run++;
      if (act !== exp) begin
         failures++;
         $display("[ERR] %0t byte %h expected %h", $time, act, exp);
      end
   endtask : check8
   // Wait for an idle host and a released ready/busy line
   task automatic wait_ready(input int bound);
      int n;
      for (n = 0; n < bound && !(bus_if.rbLine === 1'b1 && reqBusy === 1'b0); n++) begin
         @(negedge mclk);
      end
      if (n >= bound) begin
         failures++;
         $display("[ERR] %0t device never ready", $time);
         wrap_up();
      end
   endtask : wait_ready
   // One user request; the response byte lands in got
   task automatic run(input logic [2:0] kind, input logic [7:0] pre, input logic [10:0] blk);
      int n;
      logic seen;
      @(negedge mclk);
      reqValid = 1'b1;
      reqKind = kind;
      reqPrefix = pre;
      reqBlock = blk;
      @(negedge mclk);
      reqValid = 1'b0;
      seen = 1'b0;
      for (n = 0; n < 600 && !(seen && reqBusy === 1'b0); n++) begin
         @(negedge mclk);
         if (rspValid === 1'b1) begin
            seen = 1'b1;
            got = rspData;
         end
      end
      if (!seen) begin
         failures++;
         $display("[ERR] %0t request gave no response", $time);
         wrap_up();
      end
   endtask : run
   task automatic sc_status;
      run(3'h0, 8'h00, 11'h000);
      check8(got, stat(1'b1, 1'b0, 1'b0));
      wpNIn = 1'b0;
      run(3'h0, 8'h00, 11'h000);
      check8(got, stat(1'b0, 1'b0, 1'b0));
      wpNIn = 1'b1;
   endtask : sc_status
   // Program-only then erase-only on one block, full then program-only on another
   task automatic sc_protect;
      run(3'h3, CMD_PROT_PROG, 11'h005);
      run(3'h4, 8'h00, 11'h005);
      check8(got, 8'h01);
      run(3'h3, CMD_PROT_ERASE, 11'h005);
      run(3'h4, 8'h00, 11'h005);
      check8(got, 8'h03);
      run(3'h3, CMD_PROT_BOTH, 11'h006);
      run(3'h3, CMD_PROT_PROG, 11'h006);
      run(3'h4, 8'h00, 11'h006);
      check8(got, 8'h03);
      run(3'h4, 8'h00, 11'h007);
      check8(got, 8'h00);
   endtask : sc_protect
   // Erase lifts a program-only inhibit but leaves a full one in place
   task automatic sc_erase;
      run(3'h3, CMD_PROT_PROG, 11'h00B);
      run(3'h5, 8'h00, 11'h00B);
      run(3'h4, 8'h00, 11'h00B);
      check8(got, 8'h00);
      check8(activeBlock[7:0], 8'h0B);
      run(3'h5, 8'h00, 11'h005);
      run(3'h4, 8'h00, 11'h005);
      check8(got, 8'h03);
      check8(8'(erases), 8'h02);
   endtask : sc_erase
   // Confirm under write protect is refused and reported as a failure
   task automatic sc_wp_refuse;
      wpNIn = 1'b0;
      run(3'h3, CMD_PROT_BOTH, 11'h009);
      run(3'h0, 8'h00, 11'h000);
      check8(got, stat(1'b0, 1'b1, 1'b0));
      wpNIn = 1'b1;
      run(3'h4, 8'h00, 11'h009);
      check8(got, 8'h00);
   endtask : sc_wp_refuse
   // The refused confirm before this op is now the previous result
   task automatic sc_fail;
      opFail = 1'b1;
      run(3'h3, CMD_PROT_PROG, 11'h00A);
      opFail = 1'b0;
      run(3'h0, 8'h00, 11'h000);
      check8(got, stat(1'b1, 1'b1, 1'b1));
   endtask : sc_fail
   // An identifier read leaves the last program result standing
   task automatic sc_uid;
      run(3'h2, 8'h00, 11'h000);
      check8({7'h00, uidGood}, 8'h01);
      run(3'h0, 8'h00, 11'h000);
      check8(got, stat(1'b1, 1'b1, 1'b1));
   endtask : sc_uid
   // Reset command: busy for the reset time, then a pass status with the earlier failure as previous
   task automatic sc_reset;
      int n;
      int low;
      @(negedge mclk);
      reqValid = 1'b1;
      reqKind = 3'h1;
      @(negedge mclk);
      reqValid = 1'b0;
      low = 0;
      for (n = 0; n < RESET_CYCLES + 200; n++) begin
         @(negedge mclk);
         if (bus_if.rbLine === 1'b0) begin
            low++;
         end
      end
      check8(8'((low > RESET_CYCLES / 2) && (low <= RESET_CYCLES + 8)), 8'h01);
      wait_ready(100);
      run(3'h0, 8'h00, 11'h000);
      check8(got, stat(1'b1, 1'b0, 1'b1));
   endtask : sc_reset
   initial begin
      repeat (8) @(negedge mclk);
      sys_rst = 1'b0;
      wait_ready(RESET_CYCLES + 200);
      sc_status();
      sc_protect();
      sc_erase();
      sc_wp_refuse();
      sc_fail();
      sc_uid();
      sc_reset();
      wrap_up();
   end
endmodule : testbench
